// ### src/efpc_defines.svh
// Purpose: Offsets, field positions, reset values and timing figures for
//          the Ethernet FIFO partition block.
// Assumes: 32-bit APB, byte addresses, 200 MHz system clock.
// Notes:   Definitions only.
`ifndef EFPC_DEFINES_SVH
`define EFPC_DEFINES_SVH

// Register byte offsets
`define EFPC_CONFIG_OFS     8'h74
`define EFPC_RXCTL_OFS      8'h78
`define EFPC_STAT_OFS       8'h88
`define EFPC_LEVEL_OFS      8'h8C

// Field positions
`define EFPC_SWRST_BIT      0
`define EFPC_SWRST_TMO_BIT  1
`define EFPC_TXSZ_LSB       16
`define EFPC_TXSZ_MSB       19
`define EFPC_SKIP_BIT       31
`define EFPC_TXERR_BIT      16
`define EFPC_RXERR_BIT      17

// Reset values
`define EFPC_TXSZ_RST       4'h5

// Memory geometry in 32-bit words
`define EFPC_MEM_WORDS      13'h1000
`define EFPC_TXS_WORDS      13'h0080
`define EFPC_RX_FULL_GAP    13'h0004
`define EFPC_IFB_TX_WORDS   10'h200
`define EFPC_IFB_RX_WORDS   6'h20

// Timing
`define EFPC_CLK_NS         5
`define EFPC_SWRST_TMO_NS   2000

`endif

// ### src/efpc_pkg.sv
// Purpose: Types shared by the Ethernet FIFO partition block.
// Assumes: Nothing beyond SystemVerilog.
// Notes:   Constants live in efpc_defines.svh.
package efpc_pkg;
   // Soft reset sequencer, one-hot
   typedef enum logic [2:0] {
      EFPC_SR_IDLE = 3'b001,
      EFPC_SR_WAIT = 3'b010,
      EFPC_SR_GO   = 3'b100
   } efpc_sr_state_t;
endpackage

// ### src/efpc_top.sv
// Purpose: Partitioned 16 KB packet memory with MAC interface buffers,
//          receive frame skip and software reset, behind an APB slave.
// Assumes: Single clock; phy_clk_ok is asynchronous and synchronised here.
// Notes:   Status FIFOs are sized only; their words are kept elsewhere.
//
// Implementation choice: the APB slave port.
`include "efpc_defines.svh"
`timescale 1ns/10ps
`default_nettype none
module efpc_top
   import efpc_pkg::*;
(
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        rst_n,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   // PHY clock status pin
   input  wire logic        phy_clk_ok,
   // Host transmit push
   input  wire logic        tx_wr_strobe,
   input  wire logic [31:0] tx_wr_data,
   input  wire logic        tx_wr_last,
   // Host receive pull
   input  wire logic        rx_rd_req,
   output logic             rx_rd_ack,
   output logic [31:0]      rx_rd_data,
   output logic             rx_rd_last,
   // MAC transmit side
   input  wire logic        mac_tx_ready,
   output logic             mac_tx_valid,
   output logic [31:0]      mac_tx_data,
   output logic             mac_tx_last,
   // MAC receive side
   input  wire logic        mac_rx_valid,
   input  wire logic [31:0] mac_rx_data,
   input  wire logic        mac_rx_last
);

   // Soft reset timeout; a watchdog, so rounding down is harmless
   localparam int SWR_TMO_CYC = `EFPC_SWRST_TMO_NS / `EFPC_CLK_NS;

   // Allocation arithmetic, all in 32-bit words
   function automatic logic [12:0] tx_total_w(input logic [3:0] sz);
      return {1'b0, sz, 8'h00};
   endfunction
   function automatic logic [12:0] rx_total_w(input logic [3:0] sz);
      return 13'(`EFPC_MEM_WORDS - tx_total_w(sz));
   endfunction

   // Storage: shared packet memory plus the two interface buffers
   logic [32:0]    mem [0:4095];       // Bit 32 marks the last frame word
   logic [32:0]    milt [0:511];       // Transmit interface buffer
   logic [32:0]    milr [0:31];        // Receive interface buffer

   // Registers
   logic [3:0]     txsz_q;             // Partition size, soft reset immune
   logic           rd_seen_q;          // Host has read since reset
   logic           swr_req_q;          // Reset bit as software sees it
   logic           swr_tmo_q;          // Reset timed out
   efpc_sr_state_t sr_q;               // Reset sequencer
   logic [8:0]     sr_cnt_q;           // Timeout counter
   logic           skip_q;             // Frame skip in progress
   logic           tx_err_q;           // Transmit overrun
   logic           rx_err_q;           // Receive underrun
   logic [15:0]    drop_q;             // Dropped frame count
   logic [2:0]     sync_q;             // PHY clock status synchroniser
   logic           phy_ok_q;           // Filtered PHY clock status
   logic [12:0]    tx_wp_q, tx_rp_q, tx_cnt_q;
   logic [12:0]    rx_wp_q, rx_rp_q, rx_cnt_q;
   logic [8:0]     mt_wp_q, mt_rp_q;
   logic [9:0]     mt_cnt_q;
   logic [4:0]     mr_wp_q, mr_rp_q;
   logic [5:0]     mr_cnt_q;
   logic           dropping_q;         // Remainder of frame is discarded

   // Derived sizes and moves
   logic [12:0]    tx_tot, tx_dat, rx_tot, rx_dat;
   logic           swr_go, tx_push, tx_move, mt_pop;
   logic           mr_push, mr_full, rx_move, rx_full, rx_pop, skip_pop;
   logic           host_pop, drop_start;
   logic           wr_ok, acc, setup;

   // Partition of the memory follows the size field
   assign tx_tot = tx_total_w(txsz_q);
   assign tx_dat = 13'(tx_tot - `EFPC_TXS_WORDS);
   assign rx_tot = rx_total_w(txsz_q);
   assign rx_dat = 13'(rx_tot - (rx_tot >> 4));

   // Bus phases; writes are ignored until software has read once
   assign setup = psel && !penable;
   assign acc   = psel && penable;
   assign wr_ok = acc && pwrite && rd_seen_q;
   assign pready = 1'b1;
   assign pslverr = acc && !(paddr == `EFPC_CONFIG_OFS ||
                    paddr == `EFPC_RXCTL_OFS ||
                    paddr == `EFPC_STAT_OFS || paddr == `EFPC_LEVEL_OFS);

   // Transmit data path; commands and payload share one space
   assign tx_push = tx_wr_strobe && (tx_cnt_q < tx_dat);
   assign tx_move = (tx_cnt_q != 13'h0000) &&
                    (mt_cnt_q < `EFPC_IFB_TX_WORDS);
   assign mt_pop  = (mt_cnt_q != 10'h000) && mac_tx_ready;

   // Receive data path; full is declared four words early
   assign rx_full  = (rx_cnt_q >= 13'(rx_dat - `EFPC_RX_FULL_GAP));
   assign rx_move  = (mr_cnt_q != 6'h00) && !rx_full;
   assign mr_full  = (mr_cnt_q == `EFPC_IFB_RX_WORDS);
   assign mr_push  = mac_rx_valid && !mr_full && !dropping_q;
   assign drop_start = mac_rx_valid && mr_full && !dropping_q;
   assign skip_pop = skip_q && (rx_cnt_q != 13'h0000);
   assign host_pop = rx_rd_req && !skip_q && (rx_cnt_q != 13'h0000);
   assign rx_pop   = skip_pop || host_pop;
   assign swr_go   = (sr_q == EFPC_SR_GO);

   // Three-stage synchroniser; status moves once stages two and three agree
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sync_q   <= 3'h0;
         phy_ok_q <= 1'b0;
      end else begin
         sync_q <= {sync_q[1:0], phy_clk_ok};
         if (sync_q[1] == sync_q[2]) begin
            phy_ok_q <= sync_q[2];
         end
      end
   end

   // Soft reset sequencer; waits for PHY clocks or gives up
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sr_q       <= EFPC_SR_IDLE;
         sr_cnt_q   <= 9'h000;
         swr_req_q  <= 1'b0;
         swr_tmo_q  <= 1'b0;
      end else begin
         case (sr_q)
            EFPC_SR_IDLE: begin
               sr_cnt_q <= 9'h000;
               if (wr_ok && paddr == `EFPC_CONFIG_OFS &&
                   pwdata[`EFPC_SWRST_BIT]) begin
                  sr_q       <= EFPC_SR_WAIT;
                  swr_req_q  <= 1'b1;
                  swr_tmo_q  <= 1'b0;
               end
            end
            EFPC_SR_WAIT: begin
               sr_cnt_q <= 9'(sr_cnt_q + 9'h001);
               if (phy_ok_q) begin
                  sr_q <= EFPC_SR_GO;
               end else if (sr_cnt_q == 9'(SWR_TMO_CYC - 1)) begin
                  sr_q       <= EFPC_SR_IDLE;
                  swr_req_q  <= 1'b0;
                  swr_tmo_q  <= 1'b1;
               end
            end
            EFPC_SR_GO: begin
               sr_q       <= EFPC_SR_IDLE;
               swr_req_q  <= 1'b0;
            end
            default: begin
               sr_q       <= EFPC_SR_IDLE;
               swr_req_q  <= 1'b0;
            end
         endcase
      end
   end

   // Size field survives soft reset; only hard reset restores it
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         txsz_q <= `EFPC_TXSZ_RST;
      end else if (wr_ok && paddr == `EFPC_CONFIG_OFS) begin
         txsz_q <= pwdata[`EFPC_TXSZ_MSB:`EFPC_TXSZ_LSB];
      end
   end

   // Read-seen flag; a soft reset arms the first-read lock again
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rd_seen_q <= 1'b0;
      end else if (swr_go) begin
         rd_seen_q <= 1'b0;
      end else if (acc && !pwrite) begin
         rd_seen_q <= 1'b1;
      end
   end

   // Error flags; a new event wins over the soft reset clear
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         tx_err_q <= 1'b0;
         rx_err_q <= 1'b0;
      end else begin
         tx_err_q <= (tx_wr_strobe && !tx_push) ||
                     (tx_err_q && !swr_go);
         rx_err_q <= (rx_rd_req && !host_pop) ||
                     (rx_err_q && !swr_go);
      end
   end

   // Skip bit stays high until the last word of a frame is discarded or a soft reset runs
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         skip_q <= 1'b0;
      end else if (swr_go) begin
         skip_q <= 1'b0;
      end else if (wr_ok && paddr == `EFPC_RXCTL_OFS &&
                   pwdata[`EFPC_SKIP_BIT]) begin
         skip_q <= 1'b1;
      end else if (skip_pop && mem[12'(tx_tot + rx_rp_q)][32]) begin
         skip_q <= 1'b0;
      end
   end

   // Frame drop tracking; one count per lost frame
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         dropping_q <= 1'b0;
         drop_q     <= 16'h0000;
      end else if (swr_go) begin
         dropping_q <= 1'b0;
         drop_q     <= 16'h0000;
      end else begin
         if (drop_start) begin
            drop_q <= 16'(drop_q + 16'h0001);
         end
         if (mac_rx_valid && mac_rx_last) begin
            dropping_q <= 1'b0;
         end else if (drop_start) begin
            dropping_q <= 1'b1;
         end
      end
   end

   // Memory and buffer writes; TX and RX regions do not overlap for sizes 1 to 15
   always_ff @(posedge clk) begin
      if (tx_push) begin
         mem[12'(tx_wp_q)] <= {tx_wr_last, tx_wr_data};
      end
      if (rx_move) begin
         mem[12'(tx_tot + rx_wp_q)] <= milr[mr_rp_q];
      end
      if (tx_move) begin
         milt[mt_wp_q] <= mem[12'(tx_rp_q)];
      end
      if (mr_push) begin
         milr[mr_wp_q] <= {mac_rx_last, mac_rx_data};
      end
   end

   // Transmit pointers and counts; size changes need an empty path
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         tx_wp_q <= 13'h0000;
         tx_rp_q <= 13'h0000;
         tx_cnt_q <= 13'h0000;
         mt_wp_q <= 9'h000;
         mt_rp_q <= 9'h000;
         mt_cnt_q <= 10'h000;
      end else if (swr_go) begin
         tx_wp_q <= 13'h0000;
         tx_rp_q <= 13'h0000;
         tx_cnt_q <= 13'h0000;
         mt_wp_q <= 9'h000;
         mt_rp_q <= 9'h000;
         mt_cnt_q <= 10'h000;
      end else begin
         if (tx_push) begin
            tx_wp_q <= (tx_wp_q == 13'(tx_dat - 13'h0001)) ? 13'h0000 :
                       13'(tx_wp_q + 13'h0001);
         end
         if (tx_move) begin
            tx_rp_q <= (tx_rp_q == 13'(tx_dat - 13'h0001)) ? 13'h0000 :
                       13'(tx_rp_q + 13'h0001);
            mt_wp_q <= 9'(mt_wp_q + 9'h001);
         end
         if (mt_pop) begin
            mt_rp_q <= 9'(mt_rp_q + 9'h001);
         end
         tx_cnt_q <= 13'(tx_cnt_q + {12'h000, tx_push} - {12'h000, tx_move});
         mt_cnt_q <= 10'(mt_cnt_q + {9'h000, tx_move} - {9'h000, mt_pop});
      end
   end

   // Receive pointers and counts
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rx_wp_q <= 13'h0000;
         rx_rp_q <= 13'h0000;
         rx_cnt_q <= 13'h0000;
         mr_wp_q <= 5'h00;
         mr_rp_q <= 5'h00;
         mr_cnt_q <= 6'h00;
      end else if (swr_go) begin
         rx_wp_q <= 13'h0000;
         rx_rp_q <= 13'h0000;
         rx_cnt_q <= 13'h0000;
         mr_wp_q <= 5'h00;
         mr_rp_q <= 5'h00;
         mr_cnt_q <= 6'h00;
      end else begin
         if (mr_push) begin
            mr_wp_q <= 5'(mr_wp_q + 5'h01);
         end
         if (rx_move) begin
            mr_rp_q <= 5'(mr_rp_q + 5'h01);
            rx_wp_q <= (rx_wp_q == 13'(rx_dat - 13'h0001)) ? 13'h0000 :
                       13'(rx_wp_q + 13'h0001);
         end
         if (rx_pop) begin
            rx_rp_q <= (rx_rp_q == 13'(rx_dat - 13'h0001)) ? 13'h0000 :
                       13'(rx_rp_q + 13'h0001);
         end
         mr_cnt_q <= 6'(mr_cnt_q + {5'h00, mr_push} - {5'h00, rx_move});
         rx_cnt_q <= 13'(rx_cnt_q + {12'h000, rx_move} - {12'h000, rx_pop});
      end
   end

   // Data outputs, registered; ack and valid are high for one cycle per word popped
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rx_rd_ack    <= 1'b0;
         rx_rd_data   <= 32'h00000000;
         rx_rd_last   <= 1'b0;
         mac_tx_valid <= 1'b0;
         mac_tx_data  <= 32'h00000000;
         mac_tx_last  <= 1'b0;
      end else begin
         rx_rd_ack    <= host_pop;
         mac_tx_valid <= mt_pop;
         if (host_pop) begin
            {rx_rd_last, rx_rd_data} <= mem[12'(tx_tot + rx_rp_q)];
         end
         if (mt_pop) begin
            {mac_tx_last, mac_tx_data} <= milt[mt_rp_q];
         end
      end
   end

   // Read data captured in the setup cycle; levels omit interface buffers
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         prdata <= 32'h00000000;
      end else if (setup) begin
         case (paddr)
            `EFPC_CONFIG_OFS:     prdata <= {12'h000, txsz_q, 14'h0000,
                                             swr_tmo_q, swr_req_q};
            `EFPC_RXCTL_OFS:      prdata <= {skip_q, 31'h00000000};
            `EFPC_STAT_OFS:       prdata <= {14'h0000, rx_err_q, tx_err_q,
                                             drop_q};
            `EFPC_LEVEL_OFS:      prdata <= {1'b0, 13'(tx_dat - tx_cnt_q),
                                  2'b00, 1'b0, rx_cnt_q, 2'b00};
            default:              prdata <= 32'h00000000;
         endcase
      end
   end

   // Checks
   swr_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
      sr_q == EFPC_SR_GO |=> rx_cnt_q == 13'h0000 && tx_cnt_q == 13'h0000
      && drop_q == 16'h0000) else $error("soft reset left state");
   size_keep_a: assert property (@(posedge clk) disable iff (!rst_n)
      sr_q == EFPC_SR_GO |=> $stable(txsz_q))
      else $error("size field lost in soft reset");
   swr_self_a: assert property (@(posedge clk) disable iff (!rst_n)
      sr_q == EFPC_SR_GO |=> !swr_req_q && !tx_err_q && !rx_err_q)
      else $error("reset bit or error flags not cleared");
   write_lock_a: assert property (@(posedge clk) disable iff (!rst_n)
      !rd_seen_q |=> $stable(txsz_q)) else $error("write before first read");
   tx_bound_a: assert property (@(posedge clk) disable iff (!rst_n)
      tx_cnt_q <= 13'(tx_total_w(txsz_q) - 13'h0080))
      else $error("tx data overfilled");
   rx_early_a: assert property (@(posedge clk) disable iff (!rst_n)
      rx_cnt_q + 13'h0004 >= rx_dat |-> !rx_move)
      else $error("rx data filled past limit");
   drop_once_a: assert property (@(posedge clk) disable iff (!rst_n)
      drop_start ##1 (mac_rx_valid && !mac_rx_last) |=> $stable(drop_q))
      else $error("frame counted twice");
   skip_busy_a: assert property (@(posedge clk) disable iff (!rst_n)
      skip_q && rx_cnt_q == 13'h0000 && !swr_go |=> skip_q)
      else $error("skip ended with no frame end");
   swr_tmo_a: assert property (@(posedge clk) disable iff (!rst_n)
      (sr_q == EFPC_SR_WAIT && !phy_ok_q) [*8] |-> !swr_tmo_q)
      else $error("timeout flag early");

endmodule
`default_nettype wire

// ### test/efpc_mac_model.sv
// Purpose: MAC side stand-in for the FIFO partition block.
// Assumes: One word per cycle on both MAC paths.
// Notes:   Idle receive data toggles so a stale word never looks valid.
`timescale 1ns/10ps
`default_nettype none
module efpc_mac_model (
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        rst_n,
   // Transmit path from the block
   input  wire logic        hold,
   input  wire logic        mac_tx_valid,
   input  wire logic [31:0] mac_tx_data,
   input  wire logic        mac_tx_last,
   output logic             mac_tx_ready,
   // Receive path into the block
   output logic             mac_rx_valid,
   output logic [31:0]      mac_rx_data,
   output logic             mac_rx_last
);
   logic [32:0] txq [$];   // Words seen, last flag on top
   logic [32:0] rxq [$];   // Words waiting to be sent

   initial begin
      mac_tx_ready = 1'b0;
      mac_rx_valid = 1'b0;
      mac_rx_data  = 32'h0000_0000;
      mac_rx_last  = 1'b0;
   end

   // Random stalls on ready so the transmit buffer really backs up
   always @(posedge clk) begin
      mac_tx_ready <= rst_n && !hold && ($urandom_range(3) != 0);
      if (mac_tx_valid === 1'b1) begin
         txq.push_back({mac_tx_last, mac_tx_data});
      end
      if (rxq.size() > 0) begin
         {mac_rx_last, mac_rx_data} <= rxq.pop_front();
         mac_rx_valid <= 1'b1;
      end else begin
         // Idle: data changes every cycle, never holds the last word
         mac_rx_valid <= 1'b0;
         mac_rx_last  <= 1'b0;
         mac_rx_data  <= ~mac_rx_data;
      end
   end

   // Queues a frame of n words counting up from base, back to back
   task automatic send_frame(input int n, input logic [31:0] base);
      for (int i = 0; i < n; i++) begin
         rxq.push_back({i == n - 1, 32'(base + i)});
      end
   endtask
endmodule
`default_nettype wire

// ### test/testbench.sv
// Purpose: Self-checking bench for the FIFO partition block.
// Assumes: Zero-wait APB slave, MAC stand-in on the far side.
// Notes:   Sizes end at 14 so the receive fill stays short.
`include "efpc_defines.svh"
`timescale 1ns/10ps
`default_nettype none
module testbench
   import efpc_pkg::*;
;
   localparam logic [7:0] CFG = `EFPC_CONFIG_OFS;
   localparam logic [7:0] RXC = `EFPC_RXCTL_OFS;
   localparam logic [7:0] STA = `EFPC_STAT_OFS;
   localparam logic [7:0] LVL = `EFPC_LEVEL_OFS;
   // Bench signals
   logic        clk, rst_n, psel, penable, pwrite, pready, pslverr;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, tx_wr_data, rx_rd_data, mac_tx_data;
   logic [31:0] mac_rx_data, rd, b1, b2;
   logic        phy_clk_ok, tx_wr_strobe, tx_wr_last, rx_rd_req, hold;
   logic        rx_rd_ack, rx_rd_last, mac_tx_ready, mac_tx_valid;
   logic        mac_tx_last, mac_rx_valid, mac_rx_last, err;
   logic [31:0] txw [5];   // Transmit frame words
   int          error_cnt, checked, k;

   efpc_top DUT (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .phy_clk_ok(phy_clk_ok),
      .tx_wr_strobe(tx_wr_strobe), .tx_wr_data(tx_wr_data),
      .tx_wr_last(tx_wr_last), .rx_rd_req(rx_rd_req), .rx_rd_ack(rx_rd_ack),
      .rx_rd_data(rx_rd_data), .rx_rd_last(rx_rd_last),
      .mac_tx_ready(mac_tx_ready), .mac_tx_valid(mac_tx_valid),
      .mac_tx_data(mac_tx_data), .mac_tx_last(mac_tx_last),
      .mac_rx_valid(mac_rx_valid), .mac_rx_data(mac_rx_data),
      .mac_rx_last(mac_rx_last));

   efpc_mac_model mac (.clk(clk), .rst_n(rst_n), .hold(hold),
      .mac_tx_valid(mac_tx_valid), .mac_tx_data(mac_tx_data),
      .mac_tx_last(mac_tx_last), .mac_tx_ready(mac_tx_ready),
      .mac_rx_valid(mac_rx_valid), .mac_rx_data(mac_rx_data),
      .mac_rx_last(mac_rx_last));

   always #2.5 clk = ~clk;

   // Expected transmit data free bytes: total less the status part
   function automatic logic [31:0] tx_free(input int s);
      return 32'(s * 1024 - 512);
   endfunction
   // Expected receive fill limit: data part less four words
   function automatic logic [31:0] rx_full(input int s);
      int rx;
      rx = 16384 - s * 1024;
      return 32'(rx - rx / 16 - 16);
   endfunction

   task automatic chk(input string what, input logic [31:0] exp, got);
      checked++;
      if (got !== exp) begin
         $display("unexpected %s expected %h seen %h", what, exp, got);
         error_cnt++;
      end
   endtask

   // One APB transfer; held until pready is sampled high
   task automatic apb(input logic wr, input logic [7:0] a,
                      input logic [31:0] d);
      @(posedge clk);
      psel   <= 1'b1;
      pwrite <= wr;
      paddr  <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      // Only the watchdog ends a wait that never sees pready
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      rd  = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   // Soft reset with a new size, then poll until the bit clears
   task automatic soft_rst(input logic [3:0] s);
      apb(1'b1, CFG, {12'h000, s, 16'h0001});
      for (int n = 0; n < 20; n++) begin
         apb(1'b0, CFG, 32'h0000_0000);
         if (rd[0] === 1'b0) break;
      end
      chk("reset bit clear", {12'h000, s, 16'h0000}, rd);
   endtask

   // Pop one receive word and compare it
   task automatic pull(input logic [31:0] d, input logic l);
      @(posedge clk);
      rx_rd_req <= 1'b1;
      @(posedge clk);
      rx_rd_req <= 1'b0;
      @(posedge clk);
      chk("rx ack", 32'h1, {31'h0, rx_rd_ack});
      chk("rx data", d, rx_rd_data);
      chk("rx last", {31'h0, l}, {31'h0, rx_rd_last});
   endtask

   task automatic wrap_up();
      $display("checks %0d mismatches %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask

   // Watchdog: the run needs about 1400 cycles
   initial begin
      #(`EFPC_CLK_NS * 20000);
      error_cnt++;
      wrap_up();
   end

   initial begin
      {clk, rst_n, psel, penable, pwrite, paddr, pwdata} = '0;
      {tx_wr_strobe, tx_wr_data, tx_wr_last, rx_rd_req, hold} = '0;
      phy_clk_ok = 1'b1;
      error_cnt = 0;
      checked = 0;
      void'($urandom(94831));
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      // A write before the first read must be lost
      apb(1'b1, CFG, 32'h000A_0000);
      apb(1'b0, CFG, 32'h0000_0000);
      chk("config reset", 32'h0005_0000, rd);
      apb(1'b0, 8'h40, 32'h0000_0000);
      chk("unmapped err", 32'h1, {31'h0, err});
      // Sizes 2 to 14, each after a soft reset
      for (int s = 2; s <= 14; s++) begin
         soft_rst(s[3:0]);
         apb(1'b0, LVL, 32'h0000_0000);
         chk("tx free", tx_free(s), {16'h0, rd[31:16]});
      end
      // Transmit frame with the MAC stalled: level excludes the buffer
      hold <= 1'b1;
      for (int i = 0; i < 5; i++) begin
         txw[i] = $urandom;
         @(posedge clk);
         tx_wr_strobe <= 1'b1;
         tx_wr_data   <= txw[i];
         tx_wr_last   <= (i == 4);
      end
      @(posedge clk);
      tx_wr_strobe <= 1'b0;
      repeat (10) @(posedge clk);
      apb(1'b0, LVL, 32'h0000_0000);
      chk("tx free held", tx_free(14), {16'h0, rd[31:16]});
      hold <= 1'b0;
      for (k = 0; k < 200 && mac.txq.size() < 5; k++) @(posedge clk);
      for (int i = 0; i < 5; i++) begin
         chk("mac tx data", txw[i], mac.txq[i][31:0]);
         chk("mac tx last", 32'(i == 4), 32'(mac.txq[i][32]));
      end
      // Two frames in, skip from mid first frame
      b1 = $urandom;
      b2 = $urandom;
      mac.send_frame(3, b1);
      mac.send_frame(2, b2);
      repeat (20) @(posedge clk);
      apb(1'b0, LVL, 32'h0000_0000);
      chk("rx used", 32'd20, {16'h0, rd[15:0]});
      pull(b1, 1'b0);
      apb(1'b1, RXC, 32'h8000_0000);
      for (k = 0; k < 20; k++) begin
         apb(1'b0, RXC, 32'h0000_0000);
         if (rd[31] === 1'b0) break;
      end
      chk("skip done", 32'h0000_0000, rd);
      pull(b2, 1'b0);
      pull(b2 + 1, 1'b1);
      // Pull from an empty FIFO is refused and flagged
      @(posedge clk);
      rx_rd_req <= 1'b1;
      @(posedge clk);
      rx_rd_req <= 1'b0;
      @(posedge clk);
      chk("empty ack", 32'h0, {31'h0, rx_rd_ack});
      apb(1'b0, STA, 32'h0000_0000);
      chk("rx underrun", 32'h1, {31'h0, rd[`EFPC_RXERR_BIT]});
      soft_rst(4'hE);
      apb(1'b0, STA, 32'h0000_0000);
      chk("stat cleared", 32'h0000_0000, rd);
      apb(1'b0, CFG, 32'h0000_0000);
      chk("size kept", 32'h000E_0000, rd);
      // Overfill: FIFO stops four words short, buffer overruns
      for (int f = 0; f < 70; f++) mac.send_frame(8, $urandom);
      repeat (700) @(posedge clk);
      apb(1'b0, LVL, 32'h0000_0000);
      chk("rx full", rx_full(14), {16'h0, rd[15:0]});
      apb(1'b0, STA, 32'h0000_0000);
      chk("drops", 32'd7, {16'h0, rd[15:0]});
      // Soft reset without PHY clocks must time out
      phy_clk_ok <= 1'b0;
      repeat (10) @(posedge clk);
      apb(1'b1, CFG, 32'h000E_0001);
      apb(1'b0, CFG, 32'h0000_0000);
      chk("reset pending", 32'h000E_0001, rd);
      repeat (420) @(posedge clk);
      apb(1'b0, CFG, 32'h0000_0000);
      chk("reset timeout", 32'h000E_0002, rd);
      apb(1'b0, LVL, 32'h0000_0000);
      chk("level kept", rx_full(14), {16'h0, rd[15:0]});
      phy_clk_ok <= 1'b1;
      wrap_up();
   end
endmodule
`default_nettype wire
